// >>> pfi_link_assertions.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// Link checker
// ---------------------------------------------------------------
module pfi_link_assertions #(
   parameter int NGRP = 4
) (
   input  wire logic            CLK_I,
   input  wire logic            SYS_RST_I,
   input  wire logic            sync_comm_mgr_oe,
   input  wire logic            sync_comm_pol_oe,
   input  wire logic            sync_comm_line,
   input  wire logic [NGRP-1:0] grp_fault_mgr_oe,
   input  wire logic [NGRP-1:0] grp_fault_pol_oe,
   input  wire logic [NGRP-1:0] grp_fault_line,
   input  wire logic [2:0]      pol_status,
   input  wire logic            pol_running
);
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (SYS_RST_I);
   // Fault code appears or goes away
   sequence s_fault_on;  $rose(pol_status != 3'h0); endsequence
   sequence s_fault_off; $fell(pol_status != 3'h0); endsequence
   property p_line_wired;
      sync_comm_line == !(sync_comm_mgr_oe || sync_comm_pol_oe); endproperty
   property p_grp_wired;
      grp_fault_line == ~(grp_fault_mgr_oe | grp_fault_pol_oe); endproperty
   property p_reset_idle;
      $fell(SYS_RST_I) |-> !pol_running && pol_status == 3'h0; endproperty
   property p_fault_stop; s_fault_on |-> ##[0:4] !pol_running; endproperty
   property p_fault_group;
      $rose(|grp_fault_pol_oe) |-> ##[0:4] pol_status != 3'h0; endproperty
   property p_run_clean; $rose(pol_running) |-> pol_status == 3'h0; endproperty
   property p_clear_idle; s_fault_off |-> !pol_running; endproperty
   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   a_line_wired: assert property (p_line_wired)
      else $error("sync line level wrong");
   a_grp_wired: assert property (p_grp_wired)
      else $error("group line level wrong");
   a_reset_idle: assert property (p_reset_idle)
      else $error("status not idle after reset");
   a_fault_stop: assert property (p_fault_stop)
      else $error("unit kept running in fault");
   a_fault_group: assert property (p_fault_group)
      else $error("group pulled without fault");
   a_run_clean: assert property (p_run_clean)
      else $error("restart with fault shown");
   a_clear_idle: assert property (p_clear_idle)
      else $error("fault clear while running");
endmodule : pfi_link_assertions

// >>> pfi_link_if.sv
`timescale 1ns/10ps
// Shared sync/comm line (open drain) plus per-group fault lines
interface pfi_link_if #(parameter int NGRP = 4);
   logic            sync_comm_mgr_oe;  // Manager pulls line low
   logic            sync_comm_pol_oe;  // Unit pulls line low
   logic            sync_comm_line;    // Resolved wired level
   logic [NGRP-1:0] grp_fault_mgr_oe;  // Manager pulls group low
   logic [NGRP-1:0] grp_fault_pol_oe;  // Unit pulls group low
   logic [NGRP-1:0] grp_fault_line;    // Resolved, low = fault
   logic [2:0]      pol_status;        // Unit fault code to manager
   logic            pol_running;       // Unit run state
   assign sync_comm_line = ~(sync_comm_mgr_oe | sync_comm_pol_oe);
   assign grp_fault_line = ~(grp_fault_mgr_oe | grp_fault_pol_oe);
   modport pol (input sync_comm_line, grp_fault_line,
                output sync_comm_pol_oe, grp_fault_pol_oe,
                pol_status, pol_running);
   modport mgr (input sync_comm_line, grp_fault_line, pol_status,
                pol_running,
                output sync_comm_mgr_oe, grp_fault_mgr_oe);
endinterface : pfi_link_if

// >>> pfi_map.svh
`ifndef PFI_MAP_SVH
`define PFI_MAP_SVH
// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define PFI_CLK_HZ        25000000
`define PFI_HICCUP_MS     130
`define PFI_HICCUP_CYC    ((`PFI_CLK_HZ / 1000) * `PFI_HICCUP_MS)
// ---------------------------------------------------------------
// Fault code field
// ---------------------------------------------------------------
`define PFI_FCODE_W       3
`define PFI_FAULT_NONE    3'h0
`define PFI_FAULT_OT      3'h1
`define PFI_FAULT_OV      3'h2
`define PFI_FAULT_OC      3'h3
`define PFI_FAULT_UV      3'h4
// Sync/comm line frame: start + 2-bit command + stop
`define PFI_CMD_NONE      2'h0
`define PFI_CMD_ON        2'h1
`define PFI_CMD_OFF       2'h2
`define PFI_CMD_INJ       2'h3
`endif

// >>> pfi_mgr.sv
`timescale 1ns/10ps
`include "pfi_map.svh"
// Manager end: sends frames on the shared line, watches group lines
module pfi_mgr import pfi_pkg::*; #(
   parameter int NGRP     = 4,
   parameter int BIT_CYC  = 8,
   parameter int CMD_BITS = 4
) (
   input  wire logic            CLK_I,
   input  wire logic            SYS_RST_I,
   input  wire logic            CMD_VLD_I,
   input  wire logic [1:0]      CMD_I,
   pfi_link_if.mgr              link,
   output logic                 CMD_RDY_O,
   output logic [NGRP-1:0]      GRP_FAULT_O,
   output logic [2:0]           POL_STATUS_O,
   output logic                 POL_RUN_O
);
   // ---------------------------------------------------------------
   // Frame sender: start 1, cmd, stop 0; each bit low short/long
   // ---------------------------------------------------------------
   logic [CMD_BITS-1:0] sh_r, sh_nxt;
   logic [2:0]          bit_r, bit_nxt;
   logic [7:0]          ph_r, ph_nxt;
   logic                busy_r, busy_nxt;
   logic                oe_r, oe_nxt;

   // Idle sends sync-only frames so units keep switching locked.
   always_comb begin
      sh_nxt   = sh_r;
      bit_nxt  = bit_r;
      ph_nxt   = ph_r + 8'h1;
      busy_nxt = busy_r;
      if (ph_r == 8'(BIT_CYC - 1)) begin
         ph_nxt = 8'h0;
         if (bit_r == 3'(CMD_BITS - 1)) begin
            bit_nxt  = 3'h0;
            busy_nxt = CMD_VLD_I;
            sh_nxt   = CMD_VLD_I ? {1'b1, CMD_I, 1'b0} : '0;
         end else begin
            bit_nxt = bit_r + 3'h1;
            sh_nxt  = {sh_r[CMD_BITS-2:0], 1'b0};
         end
      end
      // Low 1/4 bit for 0, 3/4 bit for 1
      oe_nxt = (ph_nxt < 8'(BIT_CYC / 4)) ||
               (sh_nxt[CMD_BITS-1] && ph_nxt < 8'(3 * BIT_CYC / 4));
   end

   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         sh_r <= '0; bit_r <= 3'h0; ph_r <= 8'h0; busy_r <= 1'b0;
         oe_r <= 1'b0; CMD_RDY_O <= 1'b0; GRP_FAULT_O <= '0;
         POL_STATUS_O <= 3'h0; POL_RUN_O <= 1'b0;
      end else begin
         sh_r <= sh_nxt; bit_r <= bit_nxt; ph_r <= ph_nxt;
         busy_r <= busy_nxt; oe_r <= oe_nxt;
         CMD_RDY_O <= (ph_nxt == 8'(BIT_CYC - 1)) &&
                      (bit_nxt == 3'(CMD_BITS - 1));
         GRP_FAULT_O <= ~link.grp_fault_line;
         POL_STATUS_O <= link.pol_status;
         POL_RUN_O <= link.pol_running;
      end
   end

   assign link.sync_comm_mgr_oe = oe_r;
   assign link.grp_fault_mgr_oe = '0;
endmodule : pfi_mgr

// >>> pfi_pkg.sv
package pfi_pkg;
   // Programmed response scope of a fault type
   typedef enum logic [1:0] {
      PFI_SCOPE_UNIT   = 2'h0,
      PFI_SCOPE_GROUP  = 2'h1,
      PFI_SCOPE_SYSTEM = 2'h3
   } pfi_scope_t;
   // Converter run state, Gray along off-run-fault-hiccup
   typedef enum logic [1:0] {
      PFI_ST_OFF    = 2'h0,
      PFI_ST_RUN    = 2'h1,
      PFI_ST_FAULT  = 2'h3,
      PFI_ST_HICCUP = 2'h2
   } pfi_state_t;
endpackage : pfi_pkg

// >>> pfi_pol.sv
`timescale 1ns/10ps
`include "pfi_map.svh"
// Contract
// - Injection trigger held means simulated fault active
// - Injected fault uses the genuine fault path
// - Faults propagate by programmed response scope
// - Cross-group propagation only when enabled
// - Non-latching fault clears when trigger removed
// - Restart after hiccup timeout, group follows
// - Latching fault keeps output off until cleared
// - Enable pin toggle clears latched fault
// - Manager off clears latch, on re-enables
// - One line carries sync and commands
// - Group fault line wired to manager group
module pfi_pol import pfi_pkg::*; #(
   parameter int          NGRP       = 4,
   parameter int          GRP_ID     = 0,
   parameter int unsigned HICCUP_CYC = `PFI_HICCUP_CYC,
   parameter int          CMD_BITS   = 4
) (
   input  wire logic                   CLK_I,
   input  wire logic                   SYS_RST_I,
   input  wire logic                   EN_I,
   input  wire logic [`PFI_FCODE_W-1:0] FAULT_SRC_I,
   input  wire logic                   LATCH_I,
   input  wire pfi_scope_t             SCOPE_I,
   input  wire logic                   XGRP_EN_I,
   pfi_link_if.pol                     link,
   output logic                        OUT_ON_O,
   output logic                        SYNC_TICK_O,
   output logic [`PFI_FCODE_W-1:0]     FAULT_CODE_O
);
   // ---------------------------------------------------------------
   // Line decode
   // ---------------------------------------------------------------
   logic [CMD_BITS-1:0] sh_r, sh_nxt;
   logic [2:0]          cnt_r, cnt_nxt;
   logic [2:0]          ph_r, ph_nxt;
   logic                line_d_r, line_d_nxt;
   logic [1:0]          cmd_nxt;
   logic                cmd_vld_nxt, tick_nxt;
   logic                inj_r, inj_nxt;
   logic [`PFI_FCODE_W-1:0] inj_code_r, inj_code_nxt;

   // Frame: falling edge starts a bit; line sampled mid-bit.
   // Sample point four cycles after the edge sits between short and
   // long lows of the manager's eight-cycle bit.
   always_comb begin
      sh_nxt      = sh_r;
      cnt_nxt     = cnt_r;
      ph_nxt      = (ph_r == 3'h7) ? ph_r : ph_r + 3'h1;
      line_d_nxt  = link.sync_comm_line;
      cmd_nxt     = `PFI_CMD_NONE;
      cmd_vld_nxt = 1'b0;
      tick_nxt    = line_d_r & ~link.sync_comm_line;   // Sync edge
      if (tick_nxt) begin
         sh_nxt  = {sh_r[CMD_BITS-2:0], 1'b0};
         cnt_nxt = cnt_r + 3'h1;
         ph_nxt  = 3'h0;
      end else if (ph_r == 3'h3) begin
         sh_nxt[0] = ~link.sync_comm_line;             // Still low = 1
      end
      if (cnt_r == 3'(CMD_BITS)) begin
         cnt_nxt     = 3'h0;
         cmd_nxt     = sh_r[2:1];
         cmd_vld_nxt = sh_r[CMD_BITS-1];               // Start bit set
      end
   end

   // Injection level and code, held until next command frame.
   always_comb begin
      inj_nxt      = inj_r;
      inj_code_nxt = inj_code_r;
      if (cmd_vld_nxt && cmd_nxt == `PFI_CMD_INJ) begin
         inj_nxt      = 1'b1;
         inj_code_nxt = `PFI_FAULT_OT;
      end else if (cmd_vld_nxt) begin
         inj_nxt      = 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Fault state machine
   // ---------------------------------------------------------------
   pfi_state_t              st_r, st_nxt;
   logic [31:0]             hic_r, hic_nxt;
   logic [`PFI_FCODE_W-1:0] code_r, code_nxt;
   logic                    latch_r, latch_nxt;
   logic                    en_d_r, en_d_nxt;
   logic                    mgr_on_r, mgr_on_nxt;
   logic                    trig, ext_fault;
   logic [`PFI_FCODE_W-1:0] trig_code;
   logic                    on_nxt;
   logic [NGRP-1:0]         grp_oe_nxt;
   logic [NGRP-1:0]         grp_oe_r;

   // Injected and real triggers merge into one source.
   assign trig      = inj_r | (FAULT_SRC_I != `PFI_FAULT_NONE);
   assign trig_code = inj_r ? inj_code_r : FAULT_SRC_I;
   // Other unit in own group reported a fault.
   assign ext_fault = ~link.grp_fault_line[GRP_ID] & ~grp_oe_r[GRP_ID];

   always_comb begin
      st_nxt     = st_r;
      hic_nxt    = hic_r;
      code_nxt   = code_r;
      latch_nxt  = latch_r;
      en_d_nxt   = EN_I;
      mgr_on_nxt = mgr_on_r;
      if (cmd_vld_nxt && cmd_nxt == `PFI_CMD_ON)  mgr_on_nxt = 1'b1;
      if (cmd_vld_nxt && cmd_nxt == `PFI_CMD_OFF) mgr_on_nxt = 1'b0;
      case (st_r)
         PFI_ST_OFF: begin
            if (EN_I && mgr_on_r && !trig) st_nxt = PFI_ST_RUN;
         end
         PFI_ST_RUN: begin
            if (trig) begin
               st_nxt    = PFI_ST_FAULT;
               code_nxt  = trig_code;
               latch_nxt = LATCH_I;
            end else if (ext_fault) begin
               st_nxt    = PFI_ST_FAULT;
               latch_nxt = 1'b0;
            end else if (!EN_I || !mgr_on_r) begin
               st_nxt = PFI_ST_OFF;
            end
         end
         PFI_ST_FAULT: begin
            if (latch_r) begin
               // Stays off until enable toggle or off command
               if ((en_d_r && !EN_I) ||
                   (cmd_vld_nxt && cmd_nxt == `PFI_CMD_OFF)) begin
                  st_nxt    = PFI_ST_OFF;
                  latch_nxt = 1'b0;
                  code_nxt  = `PFI_FAULT_NONE;
               end
            end else if (!trig && !ext_fault) begin
               st_nxt   = PFI_ST_HICCUP;
               code_nxt = `PFI_FAULT_NONE;
               hic_nxt  = 32'h0;
            end
         end
         PFI_ST_HICCUP: begin
            hic_nxt = hic_r + 32'h1;
            if (trig) begin
               st_nxt    = PFI_ST_FAULT;
               code_nxt  = trig_code;
               latch_nxt = LATCH_I;
            end else if (hic_r >= 32'(HICCUP_CYC - 1)) begin
               st_nxt = PFI_ST_OFF;
            end
         end
         default: st_nxt = PFI_ST_OFF;
      endcase
   end

   // Output and group fault lines by programmed scope.
   always_comb begin
      on_nxt     = (st_nxt == PFI_ST_RUN);
      grp_oe_nxt = '0;
      if (st_nxt == PFI_ST_FAULT && code_nxt != `PFI_FAULT_NONE) begin
         if (SCOPE_I != PFI_SCOPE_UNIT)
            grp_oe_nxt[GRP_ID] = 1'b1;
         if (SCOPE_I == PFI_SCOPE_SYSTEM && XGRP_EN_I)
            grp_oe_nxt = '1;
      end
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         sh_r <= '0; cnt_r <= 3'h0; line_d_r <= 1'b1; ph_r <= 3'h7;
         inj_r <= 1'b0; inj_code_r <= `PFI_FAULT_NONE;
         st_r <= PFI_ST_OFF; hic_r <= 32'h0; code_r <= `PFI_FAULT_NONE;
         latch_r <= 1'b0; en_d_r <= 1'b0; mgr_on_r <= 1'b0;
         grp_oe_r <= '0; OUT_ON_O <= 1'b0; SYNC_TICK_O <= 1'b0;
         FAULT_CODE_O <= `PFI_FAULT_NONE;
      end else begin
         sh_r <= sh_nxt; cnt_r <= cnt_nxt; line_d_r <= line_d_nxt;
         ph_r <= ph_nxt;
         inj_r <= inj_nxt; inj_code_r <= inj_code_nxt;
         st_r <= st_nxt; hic_r <= hic_nxt; code_r <= code_nxt;
         latch_r <= latch_nxt; en_d_r <= en_d_nxt; mgr_on_r <= mgr_on_nxt;
         grp_oe_r <= grp_oe_nxt; OUT_ON_O <= on_nxt;
         SYNC_TICK_O <= tick_nxt; FAULT_CODE_O <= code_nxt;
      end
   end

   // Status back to manager; unit never drives sync line.
   assign link.sync_comm_pol_oe = 1'b0;
   assign link.grp_fault_pol_oe = grp_oe_r;
   assign link.pol_status       = FAULT_CODE_O;
   assign link.pol_running      = OUT_ON_O;
endmodule : pfi_pol

// >>> pol_fault_inject_recovery_test.sv
`timescale 1ns/10ps
`include "pfi_map.svh"
module pol_fault_inject_recovery_test import pfi_pkg::*;;
   localparam int NGRP = 4;
   localparam int HCYC = 50;
   logic            clk = 1'b0, sys_rst = 1'b1, en = 1'b0, latch = 1'b0;
   logic            xgrp = 1'b0, cmd_vld = 1'b0, prev_on = 1'b0;
   logic [2:0]      fsrc = 3'h0, code;
   logic [1:0]      cmd = 2'h0;
   pfi_scope_t      scope = PFI_SCOPE_UNIT;
   logic            out_on, tick, cmd_rdy, run;
   logic [2:0]      fcode, mstat;
   logic [NGRP-1:0] mgrp;
   logic            exp_q[$];
   int              err_total = 0, tests_run = 0, ticks = 0, n;
   int              seed = 32'h36569F71;
   always #20 clk = ~clk;
   pfi_link_if pfi_link_if_i ();
   pfi_pol #(.HICCUP_CYC(HCYC))
   pfi_pol_i (.CLK_I(clk), .SYS_RST_I(sys_rst), .EN_I(en),
      .FAULT_SRC_I(fsrc), .LATCH_I(latch), .SCOPE_I(scope), .XGRP_EN_I(xgrp),
      .link(pfi_link_if_i.pol), .OUT_ON_O(out_on), .SYNC_TICK_O(tick),
      .FAULT_CODE_O(fcode));
   pfi_mgr pfi_mgr_i (.CLK_I(clk),
      .SYS_RST_I(sys_rst), .CMD_VLD_I(cmd_vld), .CMD_I(cmd),
      .link(pfi_link_if_i.mgr), .CMD_RDY_O(cmd_rdy), .GRP_FAULT_O(mgrp),
      .POL_STATUS_O(mstat), .POL_RUN_O(run));
   pfi_link_assertions pfi_link_assertions_i (.CLK_I(clk),
      .SYS_RST_I(sys_rst), .sync_comm_line(pfi_link_if_i.sync_comm_line),
      .sync_comm_mgr_oe(pfi_link_if_i.sync_comm_mgr_oe),
      .sync_comm_pol_oe(pfi_link_if_i.sync_comm_pol_oe),
      .grp_fault_mgr_oe(pfi_link_if_i.grp_fault_mgr_oe),
      .grp_fault_pol_oe(pfi_link_if_i.grp_fault_pol_oe),
      .grp_fault_line(pfi_link_if_i.grp_fault_line),
      .pol_status(pfi_link_if_i.pol_status),
      .pol_running(pfi_link_if_i.pol_running));
   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic ok, input string m);
      tests_run++;
      if (ok !== 1'b1) begin
         err_total++;
         $display("MISMATCH at %0t: %s", $time, m);
      end
   endtask : chk
   task automatic end_of_test();
      $display("checks %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : end_of_test
   task automatic waitc(input int c);
      repeat (c) @(negedge clk);
   endtask : waitc
   // Holds the command until the manager samples it
   task automatic send(input logic [1:0] c);
      int k = 0;
      @(negedge clk);
      cmd_vld = 1'b1;
      cmd = c;
      do begin
         @(posedge clk);
         k++;
      end while (cmd_rdy !== 1'b1 && k < 300);
      chk(k < 300, "command not taken");
      @(negedge clk);
      cmd_vld = 1'b0;
   endtask : send
   task automatic wait_out(input logic v, input int lim);
      n = 0;
      while (out_on !== v && n < lim) begin
         @(negedge clk);
         n++;
      end
      chk(out_on === v, "output level not reached");
   endtask : wait_out
   // Match each output change against the oldest note
   always @(posedge clk) begin
      if (!sys_rst && out_on !== prev_on) begin
         if (exp_q.size() == 0) begin
            chk(1'b0, "unexpected output change");
         end else begin
            chk(out_on === exp_q.pop_front(), "output change wrong");
         end
      end
      prev_on = out_on;
      if (tick === 1'b1) ticks++;
   end
   // Cuts a hang short
   initial begin
      repeat (6000) @(posedge clk);
      err_total++;
      $display("MISMATCH at %0t: watchdog expired", $time);
      end_of_test();
   end
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   initial begin
      repeat (20) @(negedge clk);
      sys_rst = 1'b0;
      en = 1'b1;
      exp_q.push_back(1'b1);
      send(`PFI_CMD_ON);
      wait_out(1'b1, 100);
      waitc(8);
      chk(run === 1'b1 && mstat === `PFI_FAULT_NONE, "run status");
      $display("test startup done");
      scope = PFI_SCOPE_GROUP;
      code = 3'h1 + {1'b0, 2'($random(seed))};
      exp_q.push_back(1'b0);
      fsrc = code;
      wait_out(1'b0, 40);
      waitc(8);
      chk(fcode === code && mstat === code, "fault code");
      chk(mgrp === 4'h1, "group spread");
      waitc(100);
      exp_q.push_back(1'b1);
      fsrc = `PFI_FAULT_NONE;
      waitc(8);
      chk(fcode === `PFI_FAULT_NONE, "fault not cleared");
      wait_out(1'b1, HCYC + 40);
      chk(n + 8 >= HCYC && n + 8 <= HCYC + 16, "hiccup time");
      waitc(8);
      chk(mgrp === 4'h0, "group not restarted");
      $display("test non-latching fault done");
      scope = PFI_SCOPE_SYSTEM;
      xgrp = 1'b1;
      exp_q.push_back(1'b0);
      send(`PFI_CMD_INJ);
      wait_out(1'b0, 80);
      waitc(8);
      chk(fcode === `PFI_FAULT_OT, "injected code");
      chk(mgrp === 4'hF, "system spread");
      waitc(HCYC + 40);
      chk(out_on === 1'b0, "injection not held");
      exp_q.push_back(1'b1);
      send(`PFI_CMD_NONE);
      wait_out(1'b1, HCYC + 120);
      chk(n >= HCYC, "restart too early");
      $display("test injection done");
      scope = PFI_SCOPE_UNIT;
      xgrp = 1'b0;
      latch = 1'b1;
      code = 3'h1 + {1'b0, 2'($random(seed))};
      exp_q.push_back(1'b0);
      fsrc = code;
      wait_out(1'b0, 40);
      waitc(8);
      chk(mgrp === 4'h0, "unit scope spread");
      fsrc = `PFI_FAULT_NONE;
      waitc(HCYC + 40);
      chk(out_on === 1'b0, "latched fault restarted");
      exp_q.push_back(1'b1);
      en = 1'b0;
      waitc(4);
      en = 1'b1;
      waitc(4);
      chk(fcode === `PFI_FAULT_NONE, "enable toggle kept fault");
      send(`PFI_CMD_ON);
      wait_out(1'b1, 80);
      $display("test enable clear done");
      exp_q.push_back(1'b0);
      send(`PFI_CMD_INJ);
      wait_out(1'b0, 80);
      send(`PFI_CMD_NONE);
      waitc(HCYC + 40);
      chk(out_on === 1'b0, "latched injection restarted");
      send(`PFI_CMD_OFF);
      waitc(40);
      chk(fcode === 3'h0 && mstat === 3'h0, "off kept fault");
      exp_q.push_back(1'b1);
      send(`PFI_CMD_ON);
      wait_out(1'b1, 80);
      waitc(8);
      chk(ticks > 0 && exp_q.size() == 0, "sync ticks or notes");
      $display("test command clear done");
      end_of_test();
   end
endmodule : pol_fault_inject_recovery_test
